// file: logic/mdm_pkg.sv
// Constants and types shared by both ends of the management serial link.
// Assumes a single 10 MHz system clock on both ends.
`default_nettype none
package mdm_pkg;
	localparam int              MDM_ADDR_W        = 5;
	localparam int              MDM_DATA_W        = 16;
	localparam int              MDM_NUM_REGS      = 32;
	localparam int              MDM_FRAME_BITS    = 32;
	localparam int              MDM_HDR_BITS      = 14;
	localparam int              MDM_PRE_BITS      = 32;
	localparam logic [1:0]      MDM_SOF           = 2'h1;
	localparam logic [1:0]      MDM_OP_READ       = 2'h2;
	localparam logic [1:0]      MDM_OP_WRITE      = 2'h1;
	localparam logic [1:0]      MDM_TA_WRITE      = 2'h2;
	localparam logic [15:0]     MDM_REG_RST       = 16'h0000;
	localparam int              MDM_SYS_PERIOD_NS = 100;
	localparam int              MDM_MDC_MIN_NS    = 80;
	localparam int              MDM_MDC_HALF_MIN  =
		((MDM_MDC_MIN_NS / 2 + MDM_SYS_PERIOD_NS - 1) / MDM_SYS_PERIOD_NS < 1) ? 1 :
		(MDM_MDC_MIN_NS / 2 + MDM_SYS_PERIOD_NS - 1) / MDM_SYS_PERIOD_NS;
	localparam int              MDM_MDC_HALF_DEF  = 4;

	typedef enum logic [2:0] {
		MDM_D_IDLE,
		MDM_D_START,
		MDM_D_OP,
		MDM_D_PHY,
		MDM_D_REG,
		MDM_D_TA,
		MDM_D_DATA,
		MDM_D_LOCK
	} mdm_dev_st_e;
endpackage
`default_nettype wire

// file: logic/mdm_mgmt_if.sv
// Management pin pair between station manager and device.
// The shared data line is open-drain with a pull-up; level resolved here.
`default_nettype none
interface mdm_mgmt_if;
	logic mdc;
	logic host_mdio_o;
	logic host_mdio_oe_n;
	logic dev_mdio_o;
	logic dev_mdio_oe_n;
	logic mdio;

	// Pull-up holds one unless an enabled driver pulls low
	assign mdio = ~((~host_mdio_oe_n & ~host_mdio_o) | (~dev_mdio_oe_n & ~dev_mdio_o));

	modport host (output mdc, output host_mdio_o, output host_mdio_oe_n, input mdio);
	modport dev  (input mdc, output dev_mdio_o, output dev_mdio_oe_n, input mdio);
endinterface
`default_nettype wire

// file: logic/mdm_reg_bank.sv
// Bank of thirty-two 16-bit management registers.
// Written by the device frame decoder; read combinationally.
`default_nettype none
module mdm_reg_bank
	import mdm_pkg::*;
#(
	parameter int NUM_REGS = MDM_NUM_REGS
) (
	input  wire logic                  sys_clk,
	input  wire logic                  rst_n,
	input  wire logic                  wr_en,
	input  wire logic [MDM_ADDR_W-1:0] wr_addr,
	input  wire logic [MDM_DATA_W-1:0] wr_data,
	input  wire logic [MDM_ADDR_W-1:0] rd_addr,
	output logic      [MDM_DATA_W-1:0] rd_data
);
	logic [MDM_DATA_W-1:0] mem [NUM_REGS];

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < NUM_REGS; i++) begin
				mem[i] <= MDM_REG_RST;
			end
		end else if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
	end

	assign rd_data = mem[rd_addr];
endmodule
`default_nettype wire

// file: logic/mdm_dev.sv
// Device end of the management serial port: frame decoder and register bank.
// Assumes mdc and mdio are synchronous to sys_clk and mdc half period >= 2 cycles.
// Functional notes
// [R1] Thirty-two registers of sixteen bits each
// [R2] Registers 0-10, 15 and vendor ones present
// [R3] Bits sampled on rising management clock edge
// [R4] Manager clock rate zero to 12.5 MHz
// [R5] Frame: start, op, addresses, turnaround, data
// [R6] Frames without preamble accepted by default
// [R7] Bad start: ignore until ones then zero
// [R8] Read 10, write 01, others locked out
// [R9] Act only when address matches strapped pins
// [R10] Read turnaround: first released, second zero
// [R11] Read data valid edge to edge
// [R12] Manager holds write data around sampling edge
// [R13] Line released outside read turnaround and data
// [R14] Manager leaves one idle bit between frames
// [R15] Register written after sixteenth data bit
`default_nettype none
module mdm_dev
	import mdm_pkg::*;
(
	input  wire logic                  sys_clk,
	input  wire logic                  rst_n,
	mdm_mgmt_if.dev                    mgmt,
	input  wire logic [MDM_ADDR_W-1:0] phy_addr,
	output logic                       wr_stb,
	output logic      [MDM_ADDR_W-1:0] wr_addr,
	output logic      [MDM_DATA_W-1:0] wr_data,
	output logic                       rd_stb,
	output logic      [MDM_ADDR_W-1:0] rd_addr
);
	mdm_dev_st_e            state;
	mdm_dev_st_e            next_state;
	logic                   mdc_q;
	logic [4:0]             cnt;
	logic [1:0]             op;
	logic [MDM_ADDR_W-1:0]  phy;
	logic [MDM_ADDR_W-1:0]  reg_a;
	logic [MDM_DATA_W-1:0]  sh;
	logic                   seen_one;
	logic                   rd_act;
	logic                   drv_o;
	logic                   drv_oe_n;
	logic [MDM_DATA_W-1:0]  bank_q;

	// Shift one sampled bit into the low end of an address field
	function automatic logic [MDM_ADDR_W-1:0] shift_addr(
		input logic [MDM_ADDR_W-1:0] v,
		input logic                  b
	);
		return {v[MDM_ADDR_W-2:0], b};
	endfunction

	wire                    rise      = mgmt.mdc & ~mdc_q; // see [R3]
	wire                    bit_in    = mgmt.mdio;
	wire [1:0]              op_full   = {op[0], bit_in};
	wire [MDM_ADDR_W-1:0]   reg_full  = shift_addr(reg_a, bit_in);
	wire [MDM_ADDR_W-1:0]   phy_full  = shift_addr(phy, bit_in);
	wire                    addr_hit  = (phy == phy_addr); // see [R9]
	wire                    is_read   = (op == MDM_OP_READ);
	wire                    is_write  = (op == MDM_OP_WRITE);
	wire                    last_cnt  = (cnt == 5'h0);
	wire [MDM_DATA_W-1:0]   data_full = {sh[MDM_DATA_W-2:0], bit_in};
	wire                    do_write  = rise && state == MDM_D_DATA && last_cnt && is_write && addr_hit;
	wire                    hdr_end   = rise && state == MDM_D_REG && last_cnt;

	// Read-side drive selection
	wire                    in_ta     = (state == MDM_D_TA);
	wire                    in_data   = (state == MDM_D_DATA);
	wire                    ta_zero   = rd_act && in_ta && !last_cnt;
	wire                    data_drv  = rd_act && ((in_ta && last_cnt) || (in_data && !last_cnt));
	wire                    data_bit  = in_ta ? sh[MDM_DATA_W-1] : sh[MDM_DATA_W-2];

	mdm_reg_bank #(
		.NUM_REGS (MDM_NUM_REGS)
	) u_bank (
		.sys_clk (sys_clk),
		.rst_n   (rst_n),
		.wr_en   (do_write),
		.wr_addr (reg_a),
		.wr_data (data_full),
		.rd_addr (reg_full),
		.rd_data (bank_q)
	); // see [R1] see [R2]

	// Next frame state on each sampled bit
	always_comb begin
		next_state = state;
		unique case (state)
			MDM_D_IDLE: begin
				if (!bit_in) next_state = MDM_D_START; // see [R6]
			end
			MDM_D_START: begin
				next_state = bit_in ? MDM_D_OP : MDM_D_LOCK; // see [R7]
			end
			MDM_D_OP: begin
				if (!last_cnt) next_state = MDM_D_OP;
				else if (op_full == MDM_OP_READ || op_full == MDM_OP_WRITE) next_state = MDM_D_PHY;
				else next_state = MDM_D_LOCK; // see [R8]
			end
			MDM_D_PHY: begin
				if (last_cnt) next_state = MDM_D_REG;
			end
			MDM_D_REG: begin
				if (last_cnt) next_state = MDM_D_TA;
			end
			MDM_D_TA: begin
				if (last_cnt) next_state = MDM_D_DATA;
			end
			MDM_D_DATA: begin
				if (last_cnt) next_state = MDM_D_IDLE;
			end
			MDM_D_LOCK: begin
				if (seen_one && !bit_in) next_state = MDM_D_START; // see [R7] see [R8]
			end
		endcase
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			mdc_q <= 1'b0;
		end else begin
			mdc_q <= mgmt.mdc;
		end
	end

	// Frame decoding, advanced only on rising clock edges
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state    <= MDM_D_IDLE;
			cnt      <= 5'h0;
			op       <= 2'h0;
			phy      <= '0;
			reg_a    <= '0;
			seen_one <= 1'b0;
		end else if (rise) begin
			state <= next_state;
			unique case (state)
				MDM_D_OP: op <= op_full;
				MDM_D_PHY: phy <= phy_full;
				MDM_D_REG: reg_a <= reg_full;
				default: ;
			endcase
			seen_one <= (state == MDM_D_LOCK) && (seen_one || bit_in);
			unique case (next_state)
				MDM_D_OP: cnt <= (state == MDM_D_OP) ? 5'h0 : 5'h1;
				MDM_D_PHY, MDM_D_REG: cnt <= (state == next_state) ? cnt - 5'h1 : 5'(MDM_ADDR_W - 1);
				MDM_D_TA: cnt <= (state == next_state) ? cnt - 5'h1 : 5'h1;
				MDM_D_DATA: cnt <= (state == next_state) ? cnt - 5'h1 : 5'(MDM_DATA_W - 1);
				default: cnt <= 5'h0;
			endcase
		end
	end

	// Read drive: data shift register and turnaround zero
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			sh       <= '0;
			rd_act   <= 1'b0;
			drv_o    <= 1'b1;
			drv_oe_n <= 1'b1;
		end else if (rise) begin
			if (hdr_end) begin
				sh     <= bank_q;
				rd_act <= is_read && addr_hit; // see [R9]
			end else if (in_data) begin
				sh <= data_full;
			end
			if (ta_zero) begin
				drv_o    <= 1'b0; // see [R10]
				drv_oe_n <= 1'b0;
			end else if (data_drv) begin
				drv_o    <= data_bit; // see [R11]
				drv_oe_n <= 1'b0;
			end else begin
				drv_o    <= 1'b1; // see [R13]
				drv_oe_n <= 1'b1;
			end
			if (state == MDM_D_DATA && last_cnt) rd_act <= 1'b0;
		end
	end

	// User-side strobes: write after its last data bit, read at end of header
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_stb  <= 1'b0;
			wr_addr <= '0;
			wr_data <= '0;
			rd_stb  <= 1'b0;
			rd_addr <= '0;
		end else begin
			wr_stb <= do_write; // see [R15]
			rd_stb <= hdr_end && is_read && addr_hit; // see [R9]
			if (do_write) begin
				wr_addr <= reg_a;
				wr_data <= data_full;
			end
			if (hdr_end) rd_addr <= reg_full;
		end
	end

	assign mgmt.dev_mdio_o    = drv_o;
	assign mgmt.dev_mdio_oe_n = drv_oe_n;
endmodule
`default_nettype wire

// file: logic/mdm_host.sv
// Station manager end: builds frames, divides sys_clk into the management clock.
// Assumes the device samples on rising mdc; host changes data on falling mdc.
`default_nettype none
module mdm_host
	import mdm_pkg::*;
#(
	parameter int MDC_HALF = MDM_MDC_HALF_DEF,
	parameter int PRE_BITS = MDM_PRE_BITS
) (
	input  wire logic                  sys_clk,
	input  wire logic                  rst_n,
	mdm_mgmt_if.host                   mgmt,
	input  wire logic                  cmd_valid,
	input  wire logic                  cmd_read,
	input  wire logic [MDM_ADDR_W-1:0] cmd_phy,
	input  wire logic [MDM_ADDR_W-1:0] cmd_reg,
	input  wire logic [MDM_DATA_W-1:0] cmd_wdata,
	output logic                       cmd_ready,
	output logic                       done,
	output logic      [MDM_DATA_W-1:0] rdata
);
	logic [7:0]            div;
	logic                  mdc;
	logic                  busy;
	logic                  gap;
	logic [7:0]            pre_left;
	logic [5:0]            bits_left;
	logic [31:0]           sh;
	logic [31:0]           oem;
	logic [MDM_DATA_W-1:0] rx;
	logic                  mo;
	logic                  mo_n;

	// Never faster than the fastest allowed management clock
	localparam int HALF = (MDC_HALF < MDM_MDC_HALF_MIN) ? MDM_MDC_HALF_MIN : MDC_HALF;

	wire tick     = (div == 8'(HALF - 1)); // see [R4]
	wire fall_ev  = tick && mdc;
	wire rise_ev  = tick && !mdc;
	wire [1:0] op = cmd_read ? MDM_OP_READ : MDM_OP_WRITE;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			div <= 8'h0;
			mdc <= 1'b0;
		end else begin
			div <= tick ? 8'h0 : div + 8'h1;
			if (tick) mdc <= ~mdc;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			busy      <= 1'b0;
			gap       <= 1'b0;
			cmd_ready <= 1'b1;
			done      <= 1'b0;
			pre_left  <= 8'h0;
			bits_left <= 6'h0;
			sh        <= 32'h0;
			oem       <= 32'h0;
			rx        <= '0;
			rdata     <= '0;
			mo        <= 1'b1;
			mo_n      <= 1'b1;
		end else begin
			done <= 1'b0;
			if (rise_ev) rx <= {rx[MDM_DATA_W-2:0], mgmt.mdio}; // see [R3]
			if (cmd_valid && cmd_ready) begin
				cmd_ready <= 1'b0;
				busy      <= 1'b1;
				pre_left  <= 8'(PRE_BITS);
				bits_left <= 6'(MDM_FRAME_BITS);
				sh        <= {MDM_SOF, op, cmd_phy, cmd_reg, MDM_TA_WRITE, cmd_wdata}; // see [R5]
				oem       <= cmd_read ? {{MDM_HDR_BITS{1'b1}}, {(32 - MDM_HDR_BITS){1'b0}}} : 32'hFFFFFFFF;
			end else if (fall_ev && busy) begin
				if (pre_left != 8'h0) begin
					mo       <= 1'b1;
					mo_n     <= 1'b0;
					pre_left <= pre_left - 8'h1;
				end else if (bits_left != 6'h0) begin
					mo        <= sh[31]; // see [R12]
					mo_n      <= ~oem[31];
					sh        <= {sh[30:0], 1'b0};
					oem       <= {oem[30:0], 1'b0};
					bits_left <= bits_left - 6'h1;
				end else if (!gap) begin
					mo    <= 1'b1;
					mo_n  <= 1'b1;
					gap   <= 1'b1;
					rdata <= rx;
					done  <= 1'b1;
				end else begin
					gap       <= 1'b0; // see [R14]
					busy      <= 1'b0;
					cmd_ready <= 1'b1;
				end
			end
		end
	end

	assign mgmt.mdc            = mdc;
	assign mgmt.host_mdio_o    = mo;
	assign mgmt.host_mdio_oe_n = mo_n;
endmodule
`default_nettype wire

// file: verif/mdm_link_properties.sv
// Assertions on the management pin pair joining host and device.
// Assumes host MDC_HALF of 2 and one 10 MHz sys_clk on both ends.
`default_nettype none
module mdm_link_properties (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic mdc,
	input wire logic host_mdio_o,
	input wire logic host_mdio_oe_n,
	input wire logic dev_mdio_o,
	input wire logic dev_mdio_oe_n,
	input wire logic mdio
);
	timeunit 1ns;
	timeprecision 1ns;
	logic       mdc_q;
	logic [2:0] since;
	logic [4:0] rises;
	wire        mdc_rise = mdc & ~mdc_q;
	wire [2:0]  next_since = (since == 3'h7) ? since : since + 3'h1;
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			mdc_q <= 1'b0;
			since <= 3'h0;
			rises <= 5'h0;
		end else begin
			mdc_q <= mdc;
			since <= mdc_rise ? 3'h0 : next_since;
			rises <= dev_mdio_oe_n ? 5'h0 : rises + {4'h0, mdc_rise};
		end
	end
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	sequence s_ta_zero;
		!dev_mdio_o && !dev_mdio_oe_n;
	endsequence
	sequence s_dev_holds;
		!dev_mdio_oe_n [*3];
	endsequence
	property p_no_clash;
		!(!host_mdio_oe_n && !dev_mdio_oe_n);
	endproperty
	a_no_clash: assert property (p_no_clash)
		else $error("both ends drive the data line");
	property p_ta_zero;
		$fell(dev_mdio_oe_n) |-> s_ta_zero ##1 s_dev_holds;
	endproperty
	a_ta_zero: assert property (p_ta_zero)
		else $error("read turnaround not driven low for a bit");
	// Turnaround zero plus sixteen data bits
	property p_read_len;
		$rose(dev_mdio_oe_n) |-> rises == 5'h11;
	endproperty
	a_read_len: assert property (p_read_len)
		else $error("device drove a wrong number of data bits");
	property p_read_hold;
		!dev_mdio_oe_n && $changed(dev_mdio_o) |-> since <= 3'h2;
	endproperty
	a_read_hold: assert property (p_read_hold)
		else $error("device data changed away from the clock rise");
	property p_sample_stable;
		mdc_rise |-> $stable(mdio);
	endproperty
	a_sample_stable: assert property (p_sample_stable)
		else $error("data line moved at the clock rise");
	property p_mdc_rate;
		$rose(mdc) |-> mdc ##1 mdc ##1 !mdc;
	endproperty
	a_mdc_rate: assert property (p_mdc_rate)
		else $error("management clock high time wrong");
	property p_host_hold;
		!host_mdio_oe_n && $changed(host_mdio_o) |-> !mdc;
	endproperty
	a_host_hold: assert property (p_host_hold)
		else $error("host data changed while clock high");
	property p_idle_gap;
		$rose(host_mdio_oe_n) |-> host_mdio_oe_n [*4];
	endproperty
	a_idle_gap: assert property (p_idle_gap)
		else $error("host released the line for less than a bit");
endmodule
`default_nettype wire

// file: verif/tb.sv
// Testbench: host and device on one pin pair, a second device fed raw bits.
// Assumes the design files under logic/ are compiled first.
`default_nettype none
module tb;
	import mdm_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic        sys_clk, rst_n, cmd_valid, cmd_read, cmd_ready, done, wr_stb, wr_stb_b, rd_stb;
	logic [4:0]  cmd_phy, cmd_reg, phy_addr, wr_addr, rd_addr;
	logic [15:0] cmd_wdata, rdata, wr_data, wr_data_b;
	int          n_errors = 0, n_tests = 0, n_wr = 0, n_wr_b = 0, n_rd = 0;
	int          mem [32];
	mdm_mgmt_if m();
	mdm_mgmt_if m_b();
	mdm_host #(.MDC_HALF(2), .PRE_BITS(0)) mdm_host_i (.sys_clk(sys_clk), .rst_n(rst_n), .mgmt(m),
		.cmd_valid(cmd_valid), .cmd_read(cmd_read), .cmd_phy(cmd_phy), .cmd_reg(cmd_reg),
		.cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready), .done(done), .rdata(rdata));
	mdm_dev mdm_dev_i (.sys_clk(sys_clk), .rst_n(rst_n), .mgmt(m), .phy_addr(phy_addr), .wr_stb(wr_stb),
		.wr_addr(wr_addr), .wr_data(wr_data), .rd_stb(rd_stb), .rd_addr(rd_addr));
	mdm_dev mdm_dev_i_b (.sys_clk(sys_clk), .rst_n(rst_n), .mgmt(m_b), .phy_addr(phy_addr),
		.wr_stb(wr_stb_b), .wr_addr(), .wr_data(wr_data_b), .rd_stb(), .rd_addr());
	mdm_link_properties mdm_link_properties_i (.sys_clk(sys_clk), .rst_n(rst_n), .mdc(m.mdc),
		.host_mdio_o(m.host_mdio_o), .host_mdio_oe_n(m.host_mdio_oe_n), .dev_mdio_o(m.dev_mdio_o),
		.dev_mdio_oe_n(m.dev_mdio_oe_n), .mdio(m.mdio));
	always @(posedge sys_clk) begin
		n_wr += (wr_stb === 1'b1);
		n_wr_b += (wr_stb_b === 1'b1);
		n_rd += (rd_stb === 1'b1);
	end
	initial begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end
	task automatic finish_test();
		$display("comparisons %0d, mismatches %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			n_errors++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask
	task automatic cmd(input logic rd, input logic [4:0] phy, input logic [4:0] rg, input logic [15:0] wd);
		int k;
		k = 0;
		while (cmd_ready !== 1'b1 && k < 200) begin
			@(negedge sys_clk);
			k++;
		end
		if (k >= 200) begin
			n_errors++;
			finish_test();
		end
		{cmd_valid, cmd_read, cmd_phy, cmd_reg, cmd_wdata} = {1'b1, rd, phy, rg, wd};
		@(negedge sys_clk);
		cmd_valid = 1'b0;
		while (done !== 1'b1 && k < 1000) begin
			@(negedge sys_clk);
			k++;
		end
		if (k >= 1000) begin
			n_errors++;
			finish_test();
		end
	endtask
	task automatic wr(input logic [4:0] phy, input logic [4:0] rg, input logic [15:0] wd);
		int w;
		w = n_wr;
		cmd(1'b0, phy, rg, wd);
		repeat (3) @(negedge sys_clk);
		if (phy === phy_addr) begin
			mem[rg] = wd;
			check("write address", rg, wr_addr);
			check("write data", wd, wr_data);
		end
		check("write strobes", w + (phy === phy_addr), n_wr);
	endtask
	task automatic rd(input logic [4:0] phy, input logic [4:0] rg);
		int r;
		r = n_rd;
		cmd(1'b1, phy, rg, 16'h0000);
		check("read data", (phy === phy_addr) ? mem[rg] : 32'h0000FFFF, rdata);
		check("read strobes", r + (phy === phy_addr), n_rd);
		if (phy === phy_addr) check("read address", rg, rd_addr);
	endtask
	task automatic raw(input logic [31:0] b, input int n);
		for (int i = n - 1; i >= 0; i--) begin
			m_b.host_mdio_oe_n = b[i];
			m_b.host_mdio_o = b[i];
			repeat (2) @(negedge sys_clk);
			m_b.mdc = 1'b1;
			repeat (2) @(negedge sys_clk);
			m_b.mdc = 1'b0;
		end
		m_b.host_mdio_oe_n = 1'b1;
	endtask
	initial begin
		int k;
		{rst_n, cmd_valid, cmd_read, cmd_phy, cmd_reg, cmd_wdata} = '0;
		{m_b.mdc, m_b.host_mdio_o, m_b.host_mdio_oe_n} = 3'h3;
		void'($urandom(32'h452B));
		phy_addr = 5'($urandom);
		foreach (mem[i]) mem[i] = 0;
		repeat (10) @(negedge sys_clk);
		rst_n = 1'b1;
		for (int i = 0; i < 32; i++) rd(phy_addr, 5'(i));
		$display("reset value test done");
		repeat (40) wr(phy_addr, 5'($urandom), 16'($urandom));
		for (int i = 0; i < 32; i++) rd(phy_addr, 5'(i));
		$display("write and read test done");
		wr(phy_addr ^ 5'h01, 5'h02, 16'h1234);
		rd(phy_addr ^ 5'h01, 5'h02);
		rd(phy_addr, 5'h02);
		$display("address match test done");
		for (int i = 0; i < 3; i++) begin
			k = n_wr_b;
			raw((i == 0) ? 32'h0 : {2'h1, (i == 1) ? 2'h0 : 2'h3, 28'h0}, 32);
			repeat (3) @(negedge sys_clk);
			check("ignored frame", k, n_wr_b);
			raw(32'h3, 2);
			raw({4'h5, phy_addr, 5'h03, 2'h2, 16'hA5A5}, 32);
			repeat (3) @(negedge sys_clk);
			check("recovered frame", k + 1, n_wr_b);
			check("recovered data", 16'hA5A5, wr_data_b);
		end
		$display("bad frame test done");
		finish_test();
	end
endmodule
`default_nettype wire
